// File: design/adc_cfg_pkg.sv
// Shared constants and types for the converter serial port and configuration bank.
// Assumes byte addressing on the serial link and a 32-bit command frame.
package adc_cfg_pkg;

    // Register base byte addresses, and the byte address of the unlock key.
    localparam logic [7:0] ADDR_IDENT      = 8'h00;
    localparam logic [7:0] ADDR_RSTPWR     = 8'h04;
    localparam logic [7:0] ADDR_WPORT      = 8'h08;
    localparam logic [7:0] ADDR_OPORT      = 8'h0C;
    localparam logic [7:0] ADDR_DATAOUT    = 8'h10;
    localparam logic [7:0] ADDR_RANGE      = 8'h14;
    localparam logic [7:0] ADDR_ALARM      = 8'h20;
    localparam logic [7:0] ADDR_ALARM_HIGH = 8'h24;
    localparam logic [7:0] ADDR_ALARM_LOW  = 8'h28;
    localparam logic [7:0] ADDR_KEY_BYTE   = 8'h05;

    // Frame command codes; the values are arbitrary.
    localparam logic [7:0] CMD_WRITE = 8'hD0;
    localparam logic [7:0] CMD_READ  = 8'hC8;

    localparam logic [7:0] UNLOCK_KEY = 8'h69;

    // Field positions.
    localparam int TAG_LSB          = 16;
    localparam int TAG_W            = 4;
    localparam int KEY_LSB          = 8;
    localparam int SUPPLY_AL_BIT    = 5;
    localparam int INPUT_AL_BIT     = 4;
    localparam int RESET_CLASS_BIT  = 2;
    localparam int SLEEP_ALLOW_BIT  = 1;
    localparam int POWER_OFF_BIT    = 0;
    localparam int GPO_VALUE_BIT    = 12;
    localparam int PIN_CFG_LSB      = 8;
    localparam int CLK_SRC_BIT      = 6;

    // Reset values.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [1:0]  CFG_RESET  = 2'h0;

    // Shared pin configurations.
    localparam logic [1:0] PIN_TRISTATE = 2'h0;
    localparam logic [1:0] PIN_ALARM    = 2'h1;
    localparam logic [1:0] PIN_GENERAL  = 2'h2;
    localparam logic [1:0] PIN_LANE_B   = 2'h3;

    // Output protocol select: source-synchronous when set to this code.
    localparam logic [1:0] OUT_MODE_SRC = 2'h3;

    // Frame length and internal output clock divider.
    localparam int          FRAME_BITS     = 32;
    localparam logic [5:0]  LAST_BIT       = 6'h1F;
    localparam int          MCLK_PERIOD_NS = 25;
    localparam int          INT_CLK_NS     = 100;
    localparam int          INT_HALF_CYC   = INT_CLK_NS / (2 * MCLK_PERIOD_NS);
    localparam logic [3:0]  INT_HALF_LAST  = 4'(INT_HALF_CYC - 1);

    localparam int GEN_REGS = 5;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [7:0] pad;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] index;
    } gen_hit_t;

endpackage : adc_cfg_pkg

// File: design/adc_serial_cfg.sv
// Serial output lanes, source clock output and byte-addressed configuration bank.
// Assumes the host drives serialClk only inside frames (selectN low) and that
// frames are spaced by more than a few mclk periods.
// Overview of operation
// RULE1: Two-lane output only when second pin config equals 11b; single lane default.
// RULE2: In two-lane mode the shared alarm/general pin carries the second data lane.
// RULE3: In two-lane mode two bits launch per launch edge, one per lane.
// RULE4: Edge timing is the same in single and dual lane; only cycle count differs.
// RULE5: Source-synchronous modes drive an output clock in step with the shifted data; with the internal clock, data still launches on serialClk.
// RULE6: Clock source select picks host serial clock or internal clock for the output clock.
// RULE7: Both clock sources combine freely with one or two lane width.
// RULE8: Nine 32-bit configuration registers, each as four byte registers.
// RULE9: Bytes map least significant first onto four consecutive addresses from the base.
// RULE10: Bases 00h,04h,08h,0Ch,10h,14h,20h,24h,28h as listed.
// RULE11: Four-bit read/write unit tag in identification bits 19-16, reset zero.
// RULE12: Reserved fields are read-only and read as zero.
// RULE13: Host writes 69h to byte 05h before writing reset/power control.
// RULE14: Bits 5-0 of reset/power control update only while key holds 69h.
// RULE15: Bit 5 disables supply alarm, bit 4 disables input alarm; reset enabled.
// RULE16: Bit 2 clear gives full reset from pin; set gives application reset only.
// RULE17: Bit 1 set lets nap start when select stays high after conversion.
// RULE18: Bit 0 set powers the converter down; clear returns to active.
// RULE19: Power-on-only fields clear on power-on reset and survive application reset.
// RULE20: Host uses clock format 00 for the first write after reset.
// RULE21: Second pin config: 00 tri-state, 01 alarm, 10 general output, 11 lane.
// RULE22: A write needs at least 32 serial clocks within the frame.
// RULE23: Protected write without valid key leaves bits unchanged, no error.
// RULE24: In single lane mode only lane A shifts; shared pin keeps its function.
`timescale 1ns/1ps

module adc_serial_cfg (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        serialClk,
    input  wire logic        selectN,
    input  wire logic        serialIn,
    input  wire logic        resetPinN,
    input  wire logic        convDone,
    input  wire logic        alarmLevel,
    input  wire logic [31:0] sampleWord,
    output logic             dataOutLaneA,
    output logic             sharedPinOut,
    output logic             sharedPinOe,
    output logic             sourceClockOut,
    output logic             supplyAlarmOff,
    output logic             inputAlarmOff,
    output logic             fullPowerOff,
    output logic             napState,
    output logic [1:0]       writePortClockFormat
);

    // Register state, mclk domain.
    logic [3:0]  identTag;
    logic [7:0]  writeUnlockKey;
    logic        resetPinClassSel;
    logic        lightSleepAllow;
    logic [1:0]  clockFormat;
    logic        gpoValue;
    logic [1:0]  secondPinConfig;
    logic        outputClockSourceSel;
    logic [1:0]  outputMode;
    logic [31:0] genStore [adc_cfg_pkg::GEN_REGS];
    logic [31:0] outWord;

    // Link side, serialClk domain.
    logic [5:0]  rxCount;
    logic [30:0] rxShift;
    adc_cfg_pkg::frame_t rxFrame;
    logic        rxToggle;
    logic [5:0]  launchIdx;

    // Crossings into mclk.
    logic        tog1;
    logic        tog2;
    logic        tog3;
    logic        sel1;
    logic        selHigh;
    logic        pin1;
    logic        pinLow;
    logic        frameEvent;
    logic        fullInit;
    logic        appInit;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [1:0]  wrLane;
    adc_cfg_pkg::gen_hit_t genHit;

    logic        dualLane;
    logic        srcMode;
    logic        intClk;
    logic [3:0]  intCount;
    logic [7:0]  readByte;

    // Maps a byte address onto one of the generic stored registers.
    function automatic adc_cfg_pkg::gen_hit_t genIndex(input logic [7:0] addr);
        adc_cfg_pkg::gen_hit_t hit;
        hit.valid = 1'b1;
        unique case ({addr[7:2], 2'b00})
            adc_cfg_pkg::ADDR_DATAOUT:    hit.index = 3'h0;
            adc_cfg_pkg::ADDR_RANGE:      hit.index = 3'h1;
            adc_cfg_pkg::ADDR_ALARM:      hit.index = 3'h2;
            adc_cfg_pkg::ADDR_ALARM_HIGH: hit.index = 3'h3;
            adc_cfg_pkg::ADDR_ALARM_LOW:  hit.index = 3'h4;
            default: begin
                hit.valid = 1'b0;
                hit.index = 3'h0;
            end
        endcase
        return hit;
    endfunction : genIndex

    // Picks one byte lane of a 32-bit word, least significant first.
    function automatic logic [7:0] laneOf(input logic [31:0] word, input logic [1:0] lane);
        return word[{lane, 3'b000} +: 8];
    endfunction : laneOf

    // Full 32-bit word views of the documented registers; reserved bits read zero.
    function automatic logic [31:0] wordAt(input logic [7:0] base);
        logic [31:0] w;
        w = adc_cfg_pkg::WORD_RESET;
        unique case (base)
            adc_cfg_pkg::ADDR_IDENT: begin
                w[adc_cfg_pkg::TAG_LSB +: adc_cfg_pkg::TAG_W] = identTag; // RULE11
            end
            adc_cfg_pkg::ADDR_RSTPWR: begin
                w[adc_cfg_pkg::KEY_LSB +: 8]              = writeUnlockKey;
                w[adc_cfg_pkg::SUPPLY_AL_BIT]             = supplyAlarmOff;
                w[adc_cfg_pkg::INPUT_AL_BIT]              = inputAlarmOff;
                w[adc_cfg_pkg::RESET_CLASS_BIT]           = resetPinClassSel;
                w[adc_cfg_pkg::SLEEP_ALLOW_BIT]           = lightSleepAllow;
                w[adc_cfg_pkg::POWER_OFF_BIT]             = fullPowerOff;
            end
            adc_cfg_pkg::ADDR_WPORT: begin
                w[1:0] = clockFormat;
            end
            adc_cfg_pkg::ADDR_OPORT: begin
                w[adc_cfg_pkg::GPO_VALUE_BIT]             = gpoValue;
                w[adc_cfg_pkg::PIN_CFG_LSB +: 2]          = secondPinConfig;
                w[adc_cfg_pkg::CLK_SRC_BIT]               = outputClockSourceSel;
                w[1:0]                                    = outputMode;
            end
            default: begin
                w = adc_cfg_pkg::WORD_RESET;
            end
        endcase
        return w; // RULE12
    endfunction : wordAt

    // Frame receive: the counter is cleared by the frame's own select, since the
    // host clock stands still between frames.
    always_ff @(posedge serialClk or posedge selectN) begin
        if (selectN) begin
            rxCount <= 6'h00;
        end else if (rxCount != 6'h3F) begin
            rxCount <= rxCount + 6'h01;
        end
    end

    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            rxShift <= 31'h0000_0000;
        end else begin
            rxShift <= {rxShift[29:0], serialIn};
        end
    end

    // A frame is handed over only on its 32nd capture edge; shorter frames do nothing.
    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            rxFrame  <= adc_cfg_pkg::WORD_RESET;
            rxToggle <= 1'b0;
        end else if (!selectN && rxCount == adc_cfg_pkg::LAST_BIT) begin // RULE22
            rxFrame  <= {rxShift, serialIn};
            rxToggle <= ~rxToggle;
        end
    end

    // Launch on the falling edge; step is two bits per edge in dual-lane mode.
    always_ff @(negedge serialClk or posedge selectN) begin
        if (selectN) begin
            launchIdx <= 6'h00;
        end else if (launchIdx < adc_cfg_pkg::LAST_BIT) begin
            launchIdx <= launchIdx + (dualLane ? 6'h02 : 6'h01); // RULE3 RULE4
        end
    end

    // Lane A carries the upper bit of each pair in dual mode, every bit otherwise.
    always_comb begin
        dataOutLaneA = 1'b0;
        if (!selectN && launchIdx <= adc_cfg_pkg::LAST_BIT) begin
            dataOutLaneA = outWord[5'(adc_cfg_pkg::LAST_BIT - launchIdx)]; // RULE24
        end
    end

    assign dualLane = (secondPinConfig == adc_cfg_pkg::PIN_LANE_B); // RULE1
    assign srcMode  = (outputMode == adc_cfg_pkg::OUT_MODE_SRC);

    // Shared pin function.
    always_comb begin
        sharedPinOut = 1'b0;
        sharedPinOe  = 1'b0;
        unique case (secondPinConfig) // RULE21
            adc_cfg_pkg::PIN_TRISTATE: begin
                sharedPinOe = 1'b0;
            end
            adc_cfg_pkg::PIN_ALARM: begin
                sharedPinOut = alarmLevel;
                sharedPinOe  = 1'b1;
            end
            adc_cfg_pkg::PIN_GENERAL: begin
                sharedPinOut = gpoValue;
                sharedPinOe  = 1'b1;
            end
            adc_cfg_pkg::PIN_LANE_B: begin
                sharedPinOe = 1'b1; // RULE2
                if (!selectN && launchIdx < adc_cfg_pkg::LAST_BIT) begin
                    sharedPinOut = outWord[5'(adc_cfg_pkg::LAST_BIT - launchIdx - 6'h01)];
                end
            end
        endcase
    end

    // Output clock: a gated copy of the host clock, or the internal divider.
    // Lane width is chosen independently of the source.
    always_comb begin
        sourceClockOut = 1'b0;
        if (srcMode && !selectN) begin // RULE5 RULE7
            sourceClockOut = outputClockSourceSel ? intClk : serialClk; // RULE6
        end
    end

    // Internal clock runs only while the synchronised select shows a frame.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            intCount <= 4'h0;
            intClk   <= 1'b0;
        end else if (selHigh || !srcMode) begin
            intCount <= 4'h0;
            intClk   <= 1'b0;
        end else if (intCount == adc_cfg_pkg::INT_HALF_LAST) begin
            intCount <= 4'h0;
            intClk   <= ~intClk;
        end else begin
            intCount <= intCount + 4'h1;
        end
    end

    // Synchronisers; the second stage feeds logic, and a third toggle stage marks the frame edge.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tog1    <= 1'b0;
            tog2    <= 1'b0;
            tog3    <= 1'b0;
            sel1    <= 1'b1;
            selHigh <= 1'b1;
            pin1    <= 1'b1;
            pinLow  <= 1'b0;
        end else begin
            tog1    <= rxToggle;
            tog2    <= tog1;
            tog3    <= tog2;
            sel1    <= selectN;
            selHigh <= sel1;
            pin1    <= resetPinN;
            pinLow  <= ~pin1;
        end
    end

    // The frame fields stay stable until the next frame's 32nd edge, well after use.
    assign frameEvent = tog2 ^ tog3;
    assign wrStrobe   = frameEvent && rxFrame.cmd == adc_cfg_pkg::CMD_WRITE;
    assign rdStrobe   = frameEvent && rxFrame.cmd == adc_cfg_pkg::CMD_READ;
    assign wrLane     = rxFrame.addr[1:0];
    assign genHit     = genIndex(rxFrame.addr);
    assign fullInit   = pinLow && !resetPinClassSel; // RULE16
    assign appInit    = pinLow;

    // Power-on-only fields: cleared by power-on class resets only.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resetPinClassSel     <= 1'b0;
            lightSleepAllow      <= 1'b0;
            clockFormat          <= adc_cfg_pkg::CFG_RESET;
            outputClockSourceSel <= 1'b0;
            outputMode           <= adc_cfg_pkg::CFG_RESET;
        end else if (fullInit) begin // RULE19
            resetPinClassSel     <= 1'b0;
            lightSleepAllow      <= 1'b0;
            clockFormat          <= adc_cfg_pkg::CFG_RESET;
            outputClockSourceSel <= 1'b0;
            outputMode           <= adc_cfg_pkg::CFG_RESET;
        end else if (wrStrobe) begin
            if ({rxFrame.addr[7:2], 2'b00} == adc_cfg_pkg::ADDR_RSTPWR && wrLane == 2'h0
                && writeUnlockKey == adc_cfg_pkg::UNLOCK_KEY) begin // RULE14 RULE23
                // Once set, the class select holds until the next power cycle.
                resetPinClassSel <= resetPinClassSel
                                    | rxFrame.data[adc_cfg_pkg::RESET_CLASS_BIT];
                lightSleepAllow  <= rxFrame.data[adc_cfg_pkg::SLEEP_ALLOW_BIT]; // RULE17
            end
            if (rxFrame.addr == adc_cfg_pkg::ADDR_WPORT) begin
                clockFormat <= rxFrame.data[1:0]; // RULE20
            end
            if (rxFrame.addr == adc_cfg_pkg::ADDR_OPORT) begin
                outputClockSourceSel <= rxFrame.data[adc_cfg_pkg::CLK_SRC_BIT];
                outputMode           <= rxFrame.data[1:0];
            end
        end
    end

    // Fields cleared by any reset, power-on or application class.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            identTag        <= 4'h0;
            writeUnlockKey  <= 8'h00;
            supplyAlarmOff  <= 1'b0;
            inputAlarmOff   <= 1'b0;
            fullPowerOff    <= 1'b0;
            gpoValue        <= 1'b0;
            secondPinConfig <= adc_cfg_pkg::CFG_RESET;
        end else if (appInit) begin
            identTag        <= 4'h0;
            writeUnlockKey  <= 8'h00;
            supplyAlarmOff  <= 1'b0;
            inputAlarmOff   <= 1'b0;
            fullPowerOff    <= 1'b0;
            gpoValue        <= 1'b0;
            secondPinConfig <= adc_cfg_pkg::CFG_RESET;
        end else if (wrStrobe) begin // RULE9 RULE10
            unique case (rxFrame.addr)
                adc_cfg_pkg::ADDR_IDENT + 8'h02: begin
                    identTag <= rxFrame.data[3:0]; // RULE11
                end
                adc_cfg_pkg::ADDR_KEY_BYTE: begin
                    writeUnlockKey <= rxFrame.data; // RULE13
                end
                adc_cfg_pkg::ADDR_RSTPWR: begin
                    if (writeUnlockKey == adc_cfg_pkg::UNLOCK_KEY) begin // RULE14 RULE23
                        supplyAlarmOff <= rxFrame.data[adc_cfg_pkg::SUPPLY_AL_BIT]; // RULE15
                        inputAlarmOff  <= rxFrame.data[adc_cfg_pkg::INPUT_AL_BIT];
                        fullPowerOff   <= rxFrame.data[adc_cfg_pkg::POWER_OFF_BIT]; // RULE18
                    end
                end
                adc_cfg_pkg::ADDR_OPORT + 8'h01: begin
                    gpoValue        <= rxFrame.data[adc_cfg_pkg::GPO_VALUE_BIT - 8];
                    secondPinConfig <= rxFrame.data[1:0]; // RULE1
                end
                default: begin
                    identTag <= identTag;
                end
            endcase
        end
    end

    // Remaining registers are plain byte-writable storage.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < adc_cfg_pkg::GEN_REGS; i++) begin
                genStore[i] <= adc_cfg_pkg::WORD_RESET;
            end
        end else if (appInit) begin
            for (int i = 0; i < adc_cfg_pkg::GEN_REGS; i++) begin
                genStore[i] <= adc_cfg_pkg::WORD_RESET;
            end
        end else if (wrStrobe && genHit.valid) begin // RULE8
            genStore[genHit.index][{wrLane, 3'b000} +: 8] <= rxFrame.data;
        end
    end

    // Read data byte for the addressed location.
    always_comb begin
        if (genHit.valid) begin
            readByte = laneOf(genStore[genHit.index], wrLane);
        end else begin
            readByte = laneOf(wordAt({rxFrame.addr[7:2], 2'b00}), wrLane);
        end
    end

    // The word for the next frame: a register byte after a read, else the sample.
    // It only changes just after a frame ends, so the link side sees it settled.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            outWord <= adc_cfg_pkg::WORD_RESET;
        end else if (rdStrobe) begin
            outWord <= {readByte, 24'h00_0000};
        end else if (frameEvent) begin
            outWord <= sampleWord;
        end
    end

    // Nap begins when conversion ends with select high, and leaves on select low.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            napState <= 1'b0;
        end else if (!lightSleepAllow || !selHigh || fullPowerOff) begin
            napState <= 1'b0;
        end else if (convDone) begin // RULE17
            napState <= 1'b1;
        end
    end

    assign writePortClockFormat = clockFormat;

endmodule : adc_serial_cfg

// File: verif/adc_serial_cfg_checker.sv
// Port-level assertions for the serial configuration block.
// Assumes the host parks its serial clock low between frames.
`timescale 1ns/1ps
module adc_serial_cfg_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       selectN,
    input wire logic       resetPinN,
    input wire logic       dataOutLaneA,
    input wire logic       sharedPinOe,
    input wire logic       sourceClockOut,
    input wire logic       supplyAlarmOff,
    input wire logic       inputAlarmOff,
    input wire logic       fullPowerOff,
    input wire logic       napState,
    input wire logic [1:0] writePortClockFormat
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_idle;
        selectN [*4];
    endsequence
    sequence s_quiet;
        (selectN && resetPinN) [*6];
    endsequence
    a_srcclk_idle: assert property (s_idle |-> !sourceClockOut)
        else $error("source clock moves between frames");
    a_lane_idle: assert property (s_idle |-> !dataOutLaneA)
        else $error("lane A driven between frames");
    a_reset_clears: assert property (disable iff (1'b0) rst |-> !sharedPinOe &&
        !fullPowerOff && !napState && writePortClockFormat == 2'h0)
        else $error("outputs not cleared in reset");
    a_after_reset: assert property (disable iff (1'b0)
        $fell(rst) |-> (!fullPowerOff && !supplyAlarmOff && !inputAlarmOff) [*3])
        else $error("control bits set after reset");
    a_regs_quiet: assert property (s_quiet |-> $stable({supplyAlarmOff,
        inputAlarmOff, fullPowerOff, writePortClockFormat}))
        else $error("control bits changed with no frame");
    a_nap_select: assert property (!selectN [*5] |-> !napState)
        else $error("nap held while selected");
    a_nap_cause: assert property ($rose(napState) |-> $past(selectN, 3) && !$past(fullPowerOff))
        else $error("nap entered without cause");
    a_power_nap: assert property (fullPowerOff [*3] |-> !napState)
        else $error("nap while powered off");
endmodule : adc_serial_cfg_checker
bind adc_serial_cfg adc_serial_cfg_checker u_chk (.mclk, .rst, .selectN, .resetPinN,
    .dataOutLaneA, .sharedPinOe, .sourceClockOut, .supplyAlarmOff, .inputAlarmOff,
    .fullPowerOff, .napState, .writePortClockFormat);

// File: verif/host_model.sv
// Host controller model: drives the serial clock and frames, captures both lanes.
// Assumes it is the only master of the link; the clock is parked low between frames.
`timescale 1ns/1ps
module host_model (
    output logic      serialClk,
    output logic      selectN,
    output logic      serialIn,
    input  wire logic dataOutLaneA,
    input  wire logic sharedPinOut,
    input  wire logic sourceClockOut
);
    logic [31:0] laneA;
    logic [31:0] laneB;
    int          srcEdges;
    initial begin
        serialClk = 1'b0;
        selectN = 1'b1;
        serialIn = 1'b0;
        srcEdges = 0;
    end
    always @(posedge sourceClockOut) srcEdges++;
    // Format 00 only, so the very first write after any reset is always legal.
    task automatic frame(input logic [31:0] w);
        #5 selectN = 1'b0;
        srcEdges = 0;
        for (int i = 31; i >= 0; i--) begin
            serialIn = w[i];
            #16 serialClk = 1'b1;
            laneA[i] = dataOutLaneA;
            laneB[i] = sharedPinOut;
            #16 serialClk = 1'b0;
        end
        #16 selectN = 1'b1;
        serialIn = ~serialIn;
        #200;
    endtask : frame
endmodule : host_model

// File: verif/testbench.sv
// Self-checking bench: host model plus register, lane and output clock scenarios.
// Assumes register updates land within 8 mclk cycles after a frame ends.
`timescale 1ns/1ps
module testbench;
    logic        mclk;
    logic        rst;
    logic        resetPinN;
    logic        convDone;
    logic        alarmLevel;
    logic [31:0] sampleWord;
    logic [31:0] seed;
    logic [7:0]  val;
    int          errorCnt;
    int          checks;
    wire         sClk, selN, sIn, laneA, pinOut, pinOe, srcClk, supOff, inOff, pwrOff, nap;
    wire  [1:0]  fmt;
    localparam logic [7:0] WR = adc_cfg_pkg::CMD_WRITE;
    adc_serial_cfg u_dut (.mclk(mclk), .rst(rst), .serialClk(sClk), .selectN(selN),
        .serialIn(sIn), .resetPinN(resetPinN), .convDone(convDone), .alarmLevel(alarmLevel),
        .sampleWord(sampleWord), .dataOutLaneA(laneA), .sharedPinOut(pinOut),
        .sharedPinOe(pinOe), .sourceClockOut(srcClk), .supplyAlarmOff(supOff),
        .inputAlarmOff(inOff), .fullPowerOff(pwrOff), .napState(nap),
        .writePortClockFormat(fmt));
    host_model u_host (.serialClk(sClk), .selectN(selN), .serialIn(sIn),
        .dataOutLaneA(laneA), .sharedPinOut(pinOut), .sourceClockOut(srcClk));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Dual lane interleaves: lane A carries the odd bits, the shared pin the even ones.
    function automatic logic [31:0] got(input logic dual);
        logic [31:0] w;
        w = u_host.laneA;
        for (int k = 0; k < 16; k++) begin
            if (dual) begin
                w[31-2*k] = u_host.laneA[31-k];
                w[30-2*k] = u_host.laneB[31-k];
            end
        end
        return w;
    endfunction : got
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        if (errorCnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] d);
        u_host.frame({cmd, addr, 8'h00, d});
        repeat (2) @(posedge mclk);
    endtask : xfer
    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input logic dual);
        xfer(adc_cfg_pkg::CMD_READ, addr, 8'h00);
        xfer(8'h00, 8'h00, 8'h00);
        chk(got(dual), {exp, 24'h0000_00});
    endtask : rdchk
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        logic [7:0] bases [10];
        bases = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h18};
        seed = 32'h0000_004A;
        rst = 1'b1;
        resetPinN = 1'b1;
        convDone = 1'b0;
        alarmLevel = 1'b0;
        sampleWord = 32'h0000_0000;
        errorCnt = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        foreach (bases[i]) for (int b = 0; b < 4; b++) rdchk(bases[i] + 8'(b), 8'h00, 0);
        sampleWord <= rnd();
        xfer(8'h00, 8'h00, 8'h00);
        xfer(8'h00, 8'h00, 8'h00);
        chk(got(0), sampleWord);
        chk(pinOe, 1'b0);
        for (int i = 0; i < 5; i++) begin
            val = 8'(rnd());
            xfer(WR, bases[i+4] + 8'(val[1:0]), val);
            rdchk(bases[i+4] + 8'(val[1:0]), val, 0);
        end
        val = 8'(rnd());
        xfer(WR, 8'h02, val);
        xfer(WR, 8'h03, 8'hFF);
        rdchk(8'h02, {4'h0, val[3:0]}, 0);
        rdchk(8'h03, 8'h00, 0);
        xfer(WR, 8'h04, 8'hFF);
        chk({supOff, inOff, pwrOff}, 3'h0);
        xfer(WR, 8'h05, adc_cfg_pkg::UNLOCK_KEY);
        xfer(WR, 8'h04, 8'hFF);
        chk({supOff, inOff, pwrOff}, 3'h7);
        rdchk(8'h04, 8'h37, 0);
        xfer(WR, 8'h04, 8'h02);
        chk({supOff, inOff, pwrOff, nap}, 4'h0);
        convDone <= 1'b1;
        @(posedge mclk);
        convDone <= 1'b0;
        for (int n = 0; n < 20 && nap !== 1'b1; n++) @(posedge mclk);
        chk(nap, 1'b1);
        if (nap !== 1'b1) summarize();
        val = 8'(rnd());
        xfer(WR, 8'h08, val);
        chk(fmt, val[1:0]);
        rdchk(8'h08, {6'h00, val[1:0]}, 0);
        for (int c = 0; c < 3; c++) begin
            val = 8'(rnd());
            alarmLevel <= val[7];
            xfer(WR, 8'h0D, {3'h0, val[0], 2'h0, 2'(c)});
            chk(pinOe, c != 0);
            if (c > 0) chk(pinOut, c == 1 ? val[7] : val[0]);
        end
        xfer(WR, 8'h0D, 8'h03);
        chk(pinOe, 1'b1);
        val = 8'(rnd());
        xfer(WR, 8'h02, val);
        rdchk(8'h02, {4'h0, val[3:0]}, 1);
        xfer(WR, 8'h0C, 8'h03);
        xfer(8'h00, 8'h00, 8'h00);
        chk(32'(u_host.srcEdges), 32);
        xfer(WR, 8'h0C, 8'h43);
        rdchk(8'h02, {4'h0, val[3:0]}, 1);
        chk(u_host.srcEdges > 0, 1'b1);
        resetPinN <= 1'b0;
        repeat (3) @(posedge mclk);
        resetPinN <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(pinOe, 1'b0);
        rdchk(8'h0C, 8'h43, 0);
        rdchk(8'h04, 8'h06, 0);
        rdchk(8'h02, 8'h00, 0);
        // A power-on reset clears the class select, so the pin now does a full init.
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        xfer(WR, 8'h0C, 8'h43);
        resetPinN <= 1'b0;
        repeat (3) @(posedge mclk);
        resetPinN <= 1'b1;
        repeat (6) @(posedge mclk);
        rdchk(8'h0C, 8'h00, 0);
        summarize();
    end
endmodule : testbench
